// >>> emmb_map.svh
// Notes on behaviour
// - Buffer sits after registers; location reported
// - Software request write starts transmission
// - Buffer frozen until device acknowledges completion
// - Header 27:24 selects message kind
// - Header 23:16 is data buffer byte count
// - Data bytes follow message bytes directly
// - Header 15:8 message bytes; zero invalid
// - Enclosure protocol kinds go over I2C link
// - Serial GPIO target uses four-pin bus
// - LED message holds three LEDs per slot
// - Slot LEDs hold until next update
// - Three-bit LED codes, off and on
// - LED value bit fields per LED
// - Byte 1 low nibble is multiplier port
// - Byte 0 port; bit 5 whole enclosure
`ifndef EMMB_MAP_SVH
`define EMMB_MAP_SVH
`define EMMB_REG_WINDOW_WORDS 16'h0040
`define EMMB_BUF_WORDS 8'h40
`define EMMB_BUF_AW 6
`define EMMB_KIND_HI 27
`define EMMB_KIND_LO 24
`define EMMB_PAYLOAD_BYTE_COUNT_HI 23
`define EMMB_PAYLOAD_BYTE_COUNT_LO 16
`define EMMB_MESSAGE_BYTE_COUNT_HI 15
`define EMMB_MESSAGE_BYTE_COUNT_LO 8
`define EMMB_KIND_LED 4'h0
`define EMMB_KIND_SAFTE 4'h1
`define EMMB_KIND_SES 4'h2
`define EMMB_KIND_SGPIO 4'h3
`define EMMB_SUPPORTED 4'hF
`define EMMB_SLOTS 32
`define EMMB_LED_W 9
`define EMMB_ENCL_BIT 5
`define EMMB_CLK_HZ 50000000
`define EMMB_LINK_HZ 6250000
`define EMMB_LINK_DIV (`EMMB_CLK_HZ / `EMMB_LINK_HZ)
`endif

// >>> emmb_pkg.sv
package emmb_pkg;
  typedef enum logic [2:0] {
    EMMB_IDLE = 3'h0,
    EMMB_HDR = 3'h1,
    EMMB_BODY = 3'h3,
    EMMB_DRAIN = 3'h2,
    EMMB_DONE = 3'h6
  } emmb_state_t;
endpackage

// >>> emmb_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface emmb_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic last;
  logic [3:0] kind;
  modport src (output valid, output data, output last, output kind,
    input ready);
  modport snk (input valid, input data, input last, input kind,
    output ready);
endinterface
`default_nettype wire

// >>> emmb_link_tx.sv
`timescale 1ns/1ps
`default_nettype none
`include "emmb_map.svh"
module emmb_link_tx
  import emmb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  emmb_stream_if.snk s_in,
  input wire logic i_link_clk,
  output logic o_sclk,
  output logic o_sload,
  output logic o_sdata,
  output logic o_i2c_sda_oe,
  output logic o_busy
);
  // -----------------------------------------------------------
  // Two-entry skid buffer
  // -----------------------------------------------------------
  logic [12:0] buf_q [0:1];
  logic [1:0] cnt;
  logic wp, rp;
  logic pop;
  logic [12:0] head;
  assign s_in.ready = (cnt != 2'h2);
  assign head = buf_q[rp];
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      cnt <= 2'h0;
      wp <= 1'b0;
      rp <= 1'b0;
    end
    else
    begin
      if (s_in.valid && s_in.ready)
      begin
        buf_q[wp] <= {s_in.kind, s_in.last, s_in.data};
        wp <= ~wp;
      end
      if (pop)
        rp <= ~rp;
      cnt <= cnt + 2'((s_in.valid && s_in.ready) ? 1 : 0)
        - 2'(pop ? 1 : 0);
    end
  end
  // -----------------------------------------------------------
  // Link clock sampling, shift on falling edge
  // -----------------------------------------------------------
  logic lk_s1, lk_s2, lk_s3;
  logic fall;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      lk_s1 <= 1'b0;
      lk_s2 <= 1'b0;
      lk_s3 <= 1'b0;
    end
    else
    begin
      lk_s1 <= i_link_clk;
      lk_s2 <= lk_s1;
      lk_s3 <= lk_s2;
    end
  end
  assign fall = lk_s3 && !lk_s2;
  // -----------------------------------------------------------
  // Byte shifter
  // -----------------------------------------------------------
  logic [7:0] sh;
  logic [3:0] bits;
  logic is_i2c, sh_last;
  logic sh_on;
  assign pop = (bits == 4'h0) && (cnt != 2'h0) && fall;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      sh <= 8'h00;
      bits <= 4'h0;
      is_i2c <= 1'b0;
      sh_last <= 1'b0;
      sh_on <= 1'b0;
      o_sclk <= 1'b0;
      o_sload <= 1'b0;
      o_sdata <= 1'b0;
      o_i2c_sda_oe <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      // Clock pulses only while a bit is on the wire, never between frames
      o_sclk <= lk_s2 && sh_on;
      // Busy until the last bit's rising edge has reached the target
      o_busy <= (cnt != 2'h0) || (bits != 4'h0) || sh_on ||
        (s_in.valid && s_in.ready);
      if (pop)
      begin
        // Enclosure kinds on the I2C pin, others on four-pin bus
        is_i2c <= (head[12:9] == `EMMB_KIND_SAFTE) ||
          (head[12:9] == `EMMB_KIND_SES);
        sh <= head[7:0];
        sh_last <= head[8];
        bits <= 4'h8;
        sh_on <= 1'b0;
      end
      else if (fall && bits != 4'h0)
      begin
        // Open drain: enable low drives a one
        o_i2c_sda_oe <= is_i2c && !sh[7];
        o_sdata <= !is_i2c && sh[7];
        o_sload <= !is_i2c && sh_last && (bits == 4'h1);
        sh <= {sh[6:0], 1'b0};
        bits <= bits - 4'h1;
        sh_on <= 1'b1;
      end
      else if (fall)
      begin
        o_i2c_sda_oe <= 1'b0;
        o_sload <= 1'b0;
        sh_on <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> emmb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "emmb_map.svh"
module emmb_top
  import emmb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_buf_we,
  input wire logic [5:0] i_buf_addr,
  input wire logic [31:0] i_buf_wdata,
  input wire logic i_tx_request,
  input wire logic i_link_clk,
  output logic [31:0] o_buffer_location_reg,
  output logic o_tx_pending,
  output logic o_msg_error,
  output logic o_sclk,
  output logic o_sload,
  output logic o_sdata,
  output logic o_i2c_sda_oe,
  output logic [`EMMB_SLOTS*3-1:0] o_act_led,
  output logic [`EMMB_SLOTS*3-1:0] o_locate_led,
  output logic [`EMMB_SLOTS*3-1:0] o_fault_led,
  output logic [2:0] o_encl_value
);
  // -----------------------------------------------------------
  // Message buffer
  // -----------------------------------------------------------
  logic [31:0] mem [0:`EMMB_BUF_WORDS-1];
  logic [31:0] hdr;
  logic [31:0] rd_word;
  logic [`EMMB_BUF_AW-1:0] rd_addr;
  emmb_state_t state;
  // Writes during a pending send are dropped so the frame stays whole
  always_ff @(posedge i_ref_clk)
  begin
    if (i_buf_we && state == EMMB_IDLE)
      mem[i_buf_addr] <= i_buf_wdata;
  end
  assign rd_word = mem[rd_addr];
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_buffer_location_reg <= 32'h0;
    else
      o_buffer_location_reg <= {`EMMB_REG_WINDOW_WORDS, 8'h00,
        `EMMB_BUF_WORDS};
  end
  // -----------------------------------------------------------
  // Header fields
  // -----------------------------------------------------------
  logic [3:0] kind;
  logic [7:0] message_byte_count, payload_byte_count;
  logic [8:0] total;
  assign kind = hdr[`EMMB_KIND_HI:`EMMB_KIND_LO];
  assign payload_byte_count = hdr[`EMMB_PAYLOAD_BYTE_COUNT_HI:`EMMB_PAYLOAD_BYTE_COUNT_LO];
  assign message_byte_count = hdr[`EMMB_MESSAGE_BYTE_COUNT_HI:`EMMB_MESSAGE_BYTE_COUNT_LO];
  // Data bytes follow the message bytes with no gap
  assign total = {1'b0, message_byte_count} + {1'b0, payload_byte_count};
  // -----------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------
  emmb_stream_if strm ();
  logic [8:0] idx;
  logic [7:0] led_b0, led_b1, led_b2;
  logic bad;
  logic link_busy;
  logic [3:0] kinds_ok;
  assign rd_addr = `EMMB_BUF_AW'((idx + 9'h4) >> 2);
  // Reserved kinds, an empty message or a buffer overrun are refused
  assign kinds_ok = `EMMB_SUPPORTED;
  assign bad = (kind > `EMMB_KIND_SGPIO) || !kinds_ok[kind[1:0]] ||
    (message_byte_count == 8'h00) || (total > 9'(`EMMB_BUF_WORDS * 4 - 4));
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state <= EMMB_IDLE;
      hdr <= 32'h0;
      idx <= 9'h0;
      o_tx_pending <= 1'b0;
      o_msg_error <= 1'b0;
    end
    else
    begin
      case (state)
        EMMB_IDLE:
        begin
          if (i_tx_request)
          begin
            o_tx_pending <= 1'b1;
            o_msg_error <= 1'b0;
            hdr <= mem[0];
            idx <= 9'h0;
            state <= EMMB_HDR;
          end
        end
        EMMB_HDR:
        begin
          if (bad)
          begin
            o_msg_error <= 1'b1;
            state <= EMMB_DONE;
          end
          else if (kind == `EMMB_KIND_LED)
            state <= EMMB_DONE;
          else
            state <= EMMB_BODY;
        end
        EMMB_BODY:
        begin
          if (strm.ready)
          begin
            idx <= idx + 9'h1;
            if (idx + 9'h1 == total)
              state <= EMMB_DRAIN;
          end
        end
        EMMB_DRAIN:
        begin
          if (!link_busy && !strm.valid)
            state <= EMMB_DONE;
        end
        EMMB_DONE:
        begin
          o_tx_pending <= 1'b0;
          state <= EMMB_IDLE;
        end
        default:
          state <= EMMB_IDLE;
      endcase
    end
  end
  always_comb
  begin
    strm.valid = (state == EMMB_BODY);
    strm.last = (idx + 9'h1 == total);
    strm.kind = kind;
    case (idx[1:0])
      2'h0: strm.data = rd_word[7:0];
      2'h1: strm.data = rd_word[15:8];
      2'h2: strm.data = rd_word[23:16];
      default: strm.data = rd_word[31:24];
    endcase
  end
  emmb_link_tx u_link (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .s_in(strm.snk),
    .i_link_clk(i_link_clk),
    .o_sclk(o_sclk),
    .o_sload(o_sload),
    .o_sdata(o_sdata),
    .o_i2c_sda_oe(o_i2c_sda_oe),
    .o_busy(link_busy)
  );
  // -----------------------------------------------------------
  // LED slots
  // -----------------------------------------------------------
  logic led_go;
  logic [4:0] port;
  logic [15:0] value;
  assign led_b0 = mem[1][7:0];
  assign led_b1 = mem[1][15:8];
  assign port = led_b0[4:0];
  assign value = mem[1][31:16];
  assign led_b2 = {4'h0, led_b1[3:0]}; // multiplier port
  assign led_go = (state == EMMB_HDR) && !bad &&
    (kind == `EMMB_KIND_LED);
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_encl_value <= 3'h0;
    else if (led_go && led_b0[`EMMB_ENCL_BIT])
      o_encl_value <= value[2:0];
  end
  genvar g;
  generate
    for (g = 0; g < `EMMB_SLOTS; g++)
    begin : g_slot
      // Only a matching update touches a slot; others hold
      always_ff @(posedge i_ref_clk)
      begin
        if (i_rst)
        begin
          o_act_led[g*3 +: 3] <= 3'h0;
          o_locate_led[g*3 +: 3] <= 3'h0;
          o_fault_led[g*3 +: 3] <= 3'h0;
        end
        else if (led_go && !led_b0[`EMMB_ENCL_BIT] &&
          port == 5'(g) && led_b2 == 8'h00)
        begin
          o_act_led[g*3 +: 3] <= value[2:0];
          o_locate_led[g*3 +: 3] <= value[5:3];
          o_fault_led[g*3 +: 3] <= value[8:6];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> emmb_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "emmb_map.svh"
module emmb_top_chk
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_buf_we,
  input wire logic [5:0] i_buf_addr,
  input wire logic [31:0] i_buf_wdata,
  input wire logic i_tx_request,
  input wire logic [31:0] o_buffer_location_reg,
  input wire logic o_tx_pending,
  input wire logic o_msg_error,
  input wire logic o_i2c_sda_oe,
  input wire logic [`EMMB_SLOTS*3-1:0] o_act_led
);
  // Header shadow is frozen while pending, as the buffer is
  logic [31:0] hdr;
  logic [3:0] kind;
  logic bad;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      hdr <= 32'h0;
    else if (i_buf_we && !o_tx_pending && i_buf_addr == 6'h0)
      hdr <= i_buf_wdata;
  end
  assign kind = hdr[27:24];
  assign bad = kind > 4'h3 || hdr[15:8] == 8'h0 ||
    {1'b0, hdr[15:8]} + {1'b0, hdr[23:16]} > 9'h0FC;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_loc_value: assert property (!$past(i_rst) |->
    o_buffer_location_reg == {`EMMB_REG_WINDOW_WORDS, 8'h00,
    `EMMB_BUF_WORDS}) else $error("loc");
  a_req_pend: assert property (i_tx_request && !o_tx_pending
    |=> o_tx_pending) else $error("no pending");
  a_led_done: assert property ($rose(o_tx_pending) && !bad
    && kind == 4'h0 |-> o_tx_pending[*2] ##1 !o_tx_pending)
    else $error("led done");
  a_bad_err: assert property ($rose(o_tx_pending) && bad
    |-> ##[1:4] o_msg_error) else $error("no error");
  a_bad_quit: assert property ($rose(o_tx_pending) && bad
    |-> ##[1:6] !o_tx_pending) else $error("bad sent");
  a_good_clear: assert property ($rose(o_tx_pending) && !bad
    |-> ##[1:4] !o_msg_error) else $error("stale error");
  a_oe_kind: assert property (o_i2c_sda_oe |-> o_tx_pending &&
    (kind == 4'h1 || kind == 4'h2)) else $error("oe kind");
  a_led_hold: assert property (!$stable(o_act_led)
    |-> $past(o_tx_pending)) else $error("led moved");
endmodule
bind emmb_top emmb_top_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_buf_we(i_buf_we), .i_buf_addr(i_buf_addr), .i_buf_wdata(i_buf_wdata),
  .i_tx_request(i_tx_request), .o_tx_pending(o_tx_pending),
  .o_buffer_location_reg(o_buffer_location_reg), .o_act_led(o_act_led),
  .o_msg_error(o_msg_error), .o_i2c_sda_oe(o_i2c_sda_oe));
`default_nettype wire

// >>> emmb_target_model.sv
`timescale 1ns/1ps
`default_nettype none
module emmb_target_model
(
  input wire logic i_ref_clk,
  input wire logic i_clear,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_sda_oe,
  input wire logic i_sload,
  output logic [15:0] o_bits,
  output logic [7:0] o_loads,
  output logic [7:0] o_last,
  output logic [15:0] o_pulls
);
  // Oversampled receiver, so a glitchy clock shows as extra bits
  logic sclk_q;
  always_ff @(posedge i_ref_clk)
  begin
    sclk_q <= i_sclk;
    if (i_clear)
    begin
      o_bits <= 16'h0;
      o_pulls <= 16'h0;
      o_loads <= 8'h00;
    end
    else
    begin
      if (i_sclk && !sclk_q)
      begin
        o_bits <= o_bits + 16'h1;
        o_last <= {o_last[6:0], i_sdata};
        if (i_sload)
          o_loads <= o_loads + 8'h01;
      end
      if (i_sda_oe)
        o_pulls <= o_pulls + 16'h1;
    end
  end
endmodule
`default_nettype wire

// >>> emmb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "emmb_map.svh"
module emmb_top_tb;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, req = 1'b0, lclk = 1'b0;
  logic clr = 1'b0, pend, err, sclk, sload, sdata, oe;
  logic [5:0] addr = 6'h0;
  logic [31:0] wdata = 32'h0, loc;
  logic [`EMMB_SLOTS*3-1:0] act, lcl, flt;
  logic [2:0] encl;
  logic [15:0] bits, pulls;
  logic [7:0] lastb, loads;
  logic [31:0] hb [4] = '{32'h04000400, 32'h0F000400, 32'h0, 32'h0364C800};
  int failures = 0, compares = 0;
  always #10 clk = ~clk;
  always #80 lclk = ~lclk;
  emmb_top DUT (.i_ref_clk(clk), .i_rst(rst), .i_buf_we(we),
    .i_buf_addr(addr), .i_buf_wdata(wdata), .i_tx_request(req),
    .i_link_clk(lclk), .o_buffer_location_reg(loc), .o_tx_pending(pend),
    .o_msg_error(err), .o_sclk(sclk), .o_sload(sload), .o_sdata(sdata),
    .o_i2c_sda_oe(oe), .o_act_led(act), .o_locate_led(lcl),
    .o_fault_led(flt), .o_encl_value(encl));
  emmb_target_model u_tgt (.i_ref_clk(clk), .i_clear(clr), .i_sclk(sclk),
    .i_sdata(sdata), .i_sda_oe(oe), .i_sload(sload), .o_bits(bits),
    .o_loads(loads), .o_last(lastb), .o_pulls(pulls));
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic send(input logic [31:0] h, input logic [31:0] w1);
    wr(6'h0, h);
    wr(6'h1, w1);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    #1;
    check(pend, 1'b1);
    while (pend !== 1'b0 && n < 9000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n < 9000, 1'b1);
  endtask
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_led();
    send(32'h00000400, 32'h01E10005);
    wait_idle();
    check(act[15 +: 3], 3'h1);
    check(lcl[15 +: 3], 3'h4);
    check(flt[15 +: 3], 3'h7);
    send(32'h00000400, 32'h00080006);
    wait_idle();
    check(lcl[18 +: 3], 3'h1);
    check(act[15 +: 3], 3'h1);
    send(32'h00000400, 32'h00050025);
    wait_idle();
    check(encl, 3'h5);
    check(flt[15 +: 3], 3'h7);
    send(32'h00000400, 32'h00000305);
    wait_idle();
    check(act[15 +: 3], 3'h1);
    $display("t_led done");
  endtask
  task automatic t_bad();
    foreach (hb[i])
    begin
      send(hb[i], 32'h00000005);
      wait_idle();
      check(err, 1'b1);
      check(act[15 +: 3], 3'h1);
    end
    send(32'h00000400, 32'h00010005);
    wait_idle();
    check(err, 1'b0);
    $display("t_bad done");
  endtask
  task automatic t_sgpio();
    send(32'h03010200, 32'h00813CA5);
    wr(6'h1, 32'h00FF3CA5);
    wait_idle();
    check(bits, 16'h0018);
    check(loads, 8'h01);
    check(lastb, 8'h81);
    check(err, 1'b0);
    $display("t_sgpio done");
  endtask
  task automatic t_i2c();
    for (int k = 1; k < 3; k++)
    begin
      send({4'h0, k[3:0], 24'h000100}, 32'h0);
      wait_idle();
      check(pulls, 16'h0040);
      check(bits, 16'h0008);
      check(loads, 8'h00);
    end
    $display("t_i2c done");
  endtask
  initial
  begin
    #1_000_000;
    failures++;
    report_and_stop();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(loc, {`EMMB_REG_WINDOW_WORDS, 8'h00, `EMMB_BUF_WORDS});
    check(pend, 1'b0);
    $display("t_reset done");
    t_led();
    t_bad();
    t_sgpio();
    t_i2c();
    report_and_stop();
  end
endmodule
`default_nettype wire
